// ### rtl/rgbc_light_sensor_regs.sv
// Register file and conversion sequencer of the four-channel RGBC light sensor
//
// Behaviour
// - External timing select set means slots are timed by the external clock input.
// - Sleep holds only in external clock mode; otherwise the device clears it itself.
// - Trim offset select one enables trim offset mode, zero disables it.
// - Each channel has a capacitor count in bits 3:0; bits 7:4 unused.
// - Integration time is 12 slots count split over low byte and high nibble.
// - Ten-bit result is read as low byte and high byte bits 1:0.
// - Zero-level register holds magnitude in bits 6:0 and polarity in bit 7.
// - Polarity bit reads zero for positive offset, one for negative.
// - Unused bit positions carry no meaning and read as zero.
// - Host writes sensor request one; device clears it and fills results 64 to 71.
// - Host writes offset request one; device clears it and fills offsets 72 to 75.
`timescale 1ns/100ps
`default_nettype none
`include "rgbc_consts.svh"
module rgbc_light_sensor_regs (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic EXT_CLK,
  input wire rgbc_pkg::sample_set_t SAMPLE_RAW,
  input wire rgbc_pkg::zero_set_t ZERO_RAW,
  output logic [15:0] CAP_SETTING,
  output logic CLOCK_EXTERNAL,
  output logic SLEEP_ACTIVE,
  output logic CONV_BUSY
);

  typedef struct packed {
    logic external_timing_select;
    logic sleep;
    logic trim_offset_select;
    logic sensor_reading_request;
    logic offset_reading_request;
    logic [3:0][3:0] cap;
    logic [3:0][11:0] slots;
    rgbc_pkg::zero_set_t zero;
    rgbc_pkg::seq_state_t state;
    logic [`SLOT_CNT_W-1:0] div;
    logic ext_prev;
    logic [7:0] rdata;
  } top_state_t;

  localparam logic [`SLOT_CNT_W-1:0] SLOT_LAST = `SLOT_CNT_W'(`SLOT_CYCLES - 1);

  top_state_t s_q;
  top_state_t s_d;
  logic tick;
  logic int_tick;
  logic ext_tick;
  logic start;
  logic [3:0] busy;
  rgbc_pkg::sample_set_t result;
  logic [7:0] rd_val;

  // ****************************************
  // Slot timing source
  // ****************************************
  // External edge or internal divider; the divider keeps counting while asleep, but no slot tick is given
  assign int_tick = (s_q.div == SLOT_LAST);
  assign ext_tick = EXT_CLK && !s_q.ext_prev;
  assign tick = (s_q.external_timing_select ? ext_tick : int_tick) && !s_q.sleep;
  assign start = (s_q.state == rgbc_pkg::ST_IDLE) && s_q.sensor_reading_request && !s_q.sleep;

  // ****************************************
  // Channels
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      rgbc_channel u_chan (
        .clk(CLK),
        .rst_n(RST_N),
        .start(start),
        .tick(tick),
        .slots(s_q.slots[ch]),
        .trim_on(s_q.trim_offset_select),
        .zero(s_q.zero[ch]),
        .raw(SAMPLE_RAW[ch]),
        .result(result[ch]),
        .busy(busy[ch])
      );
      assign CAP_SETTING[4*ch +: 4] = s_q.cap[ch];
    end
  endgenerate

  // ****************************************
  // Read decode
  // ****************************************
  // Unused bits and unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    if (REG_ADDR == `ADDR_CTRL) begin
      rd_val[`CTRL_SENSOR_BIT] = s_q.sensor_reading_request;
      rd_val[`CTRL_OFFSET_BIT] = s_q.offset_reading_request;
    end
    if (REG_ADDR == `ADDR_SETUP) begin
      rd_val[`SETUP_EXT_BIT] = s_q.external_timing_select;
      rd_val[`SETUP_SLEEP_BIT] = s_q.sleep;
      rd_val[`SETUP_TRIM_BIT] = s_q.trim_offset_select;
    end
    for (int i = 0; i < 4; i++) begin
      if (REG_ADDR == `ADDR_CAP_BASE + 8'(i)) begin
        rd_val = {4'h0, s_q.cap[i]};
      end
      if (REG_ADDR == `ADDR_SLOTS_BASE + 8'(2 * i)) begin
        rd_val = s_q.slots[i][7:0];
      end
      if (REG_ADDR == `ADDR_SLOTS_BASE + 8'(2 * i + 1)) begin
        rd_val = {4'h0, s_q.slots[i][11:8]};
      end
      if (REG_ADDR == `ADDR_RESULT_BASE + 8'(2 * i)) begin
        rd_val = result[i][7:0];
      end
      if (REG_ADDR == `ADDR_RESULT_BASE + 8'(2 * i + 1)) begin
        rd_val = {6'h00, result[i][9:8]};
      end
      if (REG_ADDR == `ADDR_ZERO_BASE + 8'(i)) begin
        rd_val = s_q.zero[i];
      end
    end
  end

  // ****************************************
  // Next state: writes, sequencer, divider
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.ext_prev = EXT_CLK;
    s_d.div = int_tick ? '0 : s_q.div + `SLOT_CNT_W'(1);
    if (REG_RD) begin
      s_d.rdata = rd_val;
    end

    // Sequencer; completion clears a request, a same-cycle host write re-sets it below
    unique case (s_q.state)
      rgbc_pkg::ST_IDLE: begin
        if (start) begin
          s_d.state = rgbc_pkg::ST_CONVERT;
        end else if (s_q.offset_reading_request && !s_q.sleep) begin
          s_d.state = rgbc_pkg::ST_OFFSET;
        end
      end
      rgbc_pkg::ST_CONVERT: begin
        if (busy == 4'h0) begin
          s_d.sensor_reading_request = 1'b0;
          s_d.state = rgbc_pkg::ST_IDLE;
        end
      end
      rgbc_pkg::ST_OFFSET: begin
        if (tick) begin
          s_d.zero = ZERO_RAW;
          s_d.offset_reading_request = 1'b0;
          s_d.state = rgbc_pkg::ST_IDLE;
        end
      end
    endcase

    // Host writes; read-only registers ignore writes
    if (REG_WR) begin
      if (REG_ADDR == `ADDR_CTRL) begin
        // Writing one starts; writing zero does not abort a running reading
        if (REG_WDATA[`CTRL_SENSOR_BIT]) begin
          s_d.sensor_reading_request = 1'b1;
        end
        if (REG_WDATA[`CTRL_OFFSET_BIT]) begin
          s_d.offset_reading_request = 1'b1;
        end
      end
      if (REG_ADDR == `ADDR_SETUP) begin
        s_d.external_timing_select = REG_WDATA[`SETUP_EXT_BIT];
        s_d.sleep = REG_WDATA[`SETUP_SLEEP_BIT];
        s_d.trim_offset_select = REG_WDATA[`SETUP_TRIM_BIT];
      end
      for (int i = 0; i < 4; i++) begin
        if (REG_ADDR == `ADDR_CAP_BASE + 8'(i)) begin
          s_d.cap[i] = REG_WDATA[3:0];
        end
        if (REG_ADDR == `ADDR_SLOTS_BASE + 8'(2 * i)) begin
          s_d.slots[i][7:0] = REG_WDATA;
        end
        if (REG_ADDR == `ADDR_SLOTS_BASE + 8'(2 * i + 1)) begin
          s_d.slots[i][11:8] = REG_WDATA[3:0];
        end
      end
    end

    // Sleep cannot stand without external clock mode
    if (!s_d.external_timing_select) begin
      s_d.sleep = 1'b0;
    end
  end

  // Registered state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_q <= '0;
      for (int i = 0; i < 4; i++) begin
        s_q.cap[i] <= `CAP_RESET;
        s_q.slots[i] <= `SLOTS_RESET;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign REG_RDATA = s_q.rdata;
  assign CLOCK_EXTERNAL = s_q.external_timing_select;
  assign SLEEP_ACTIVE = s_q.sleep;
  assign CONV_BUSY = (s_q.state != rgbc_pkg::ST_IDLE);

endmodule // rgbc_light_sensor_regs
`default_nettype wire

// ### rtl/rgbc_consts.svh
// Register offsets, field positions, reset values and timing counts of the RGBC sensor block
`ifndef RGBC_CONSTS_SVH
`define RGBC_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_CTRL 8'h00
`define ADDR_SETUP 8'h01
`define ADDR_CAP_BASE 8'h06
`define ADDR_SLOTS_BASE 8'h0A
`define ADDR_RESULT_BASE 8'h40
`define ADDR_ZERO_BASE 8'h48

// ****************************************
// Field positions
// ****************************************
`define CTRL_SENSOR_BIT 0
`define CTRL_OFFSET_BIT 1
`define SETUP_TRIM_BIT 0
`define SETUP_SLEEP_BIT 1
`define SETUP_EXT_BIT 2

// ****************************************
// Reset values
// ****************************************
`define CAP_RESET 4'h0F
`define SLOTS_RESET 12'h000

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 5
`define SLOT_TIME_NS 1000
`define SLOT_CYCLES ((`SLOT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOT_CNT_W 8

`endif

// ### rtl/rgbc_pkg.sv
// Types shared by the RGBC sensor block
`default_nettype none
package rgbc_pkg;

  typedef logic [9:0] sample_t;
  typedef sample_t [3:0] sample_set_t;

  // Sign-magnitude zero-level reading
  typedef struct packed {
    logic negative;
    logic [6:0] magnitude;
  } zero_level_t;

  typedef zero_level_t [3:0] zero_set_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_OFFSET
  } seq_state_t;

endpackage
`default_nettype wire

// ### rtl/rgbc_channel.sv
// One colour channel: slot counting, result capture and trim correction
`timescale 1ns/100ps
`default_nettype none
module rgbc_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic tick,
  input wire logic [11:0] slots,
  input wire logic trim_on,
  input wire rgbc_pkg::zero_level_t zero,
  input wire rgbc_pkg::sample_t raw,
  output rgbc_pkg::sample_t result,
  output logic busy
);

  typedef struct packed {
    logic [11:0] cnt;
    logic busy;
    rgbc_pkg::sample_t result;
  } chan_state_t;

  chan_state_t s_q;
  chan_state_t s_d;
  logic [10:0] fixed;

  // ****************************************
  // Trim correction, clamped to 10 bits
  // ****************************************
  // Positive zero level is a bias to remove; negative one is added back
  always_comb begin
    if (zero.negative) begin
      fixed = {1'b0, raw} + {4'h0, zero.magnitude};
    end else begin
      fixed = {1'b0, raw} - {4'h0, zero.magnitude};
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.cnt = slots;
      s_d.busy = 1'b1;
    end else if (s_q.busy && tick) begin
      if (s_q.cnt == 12'h000) begin
        s_d.busy = 1'b0;
        if (!trim_on) begin
          s_d.result = raw;
        end else if (fixed[10]) begin
          // Overflow on add saturates high, underflow on subtract floors at zero
          s_d.result = zero.negative ? 10'h3FF : 10'h000;
        end else begin
          s_d.result = fixed[9:0];
        end
      end else begin
        s_d.cnt = s_q.cnt - 12'h001;
      end
    end
  end

  // Registered state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign result = s_q.result;
  assign busy = s_q.busy;

endmodule // rgbc_channel
`default_nettype wire

// ### verif/host_model.sv
// Host side of the register port: one-cycle strobes and result pairing
`timescale 1ns/100ps
`default_nettype none
`include "rgbc_consts.svh"
module host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata
);
  // Idle port at time zero
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // Strobe held through exactly one sampling edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    wdata = ~d; // Stale data never lingers
  endtask
  // Data taken once the read edge has landed
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdata;
  endtask
  // Both bytes read after the request bit cleared
  task automatic rd_result(input int ch, output logic [9:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd_reg(8'(`ADDR_RESULT_BASE + 2 * ch), lo);
    rd_reg(8'(`ADDR_RESULT_BASE + 2 * ch + 1), hi);
    v = {hi[1:0], lo};
  endtask
endmodule // host_model
`default_nettype wire

// ### verif/rgbc_light_sensor_regs_properties.sv
// Port-level checks of the RGBC sensor register block
`timescale 1ns/100ps
`default_nettype none
`include "rgbc_consts.svh"
module rgbc_light_sensor_regs_properties (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic EXT_CLK,
  input wire rgbc_pkg::sample_set_t SAMPLE_RAW,
  input wire rgbc_pkg::zero_set_t ZERO_RAW,
  input wire logic [15:0] CAP_SETTING,
  input wire logic CLOCK_EXTERNAL,
  input wire logic SLEEP_ACTIVE,
  input wire logic CONV_BUSY
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Start is taken one edge after the write, busy the edge after
  sequence start_req;
    REG_WR && REG_ADDR == `ADDR_CTRL && REG_WDATA[0] && !CONV_BUSY && !SLEEP_ACTIVE;
  endsequence
  sequence busy_rise;
    !CONV_BUSY ##1 CONV_BUSY;
  endsequence
  sequence setup_wr;
    REG_WR && REG_ADDR == `ADDR_SETUP;
  endsequence
  chk_busy_start: assert property (start_req |=> busy_rise)
    else $error("conversion did not start");
  chk_sleep_ext: assert property (SLEEP_ACTIVE |-> CLOCK_EXTERNAL)
    else $error("sleep without external clock");
  chk_sleep_no_start: assert property (SLEEP_ACTIVE && !CONV_BUSY |=> !CONV_BUSY)
    else $error("reading started while asleep");
  chk_setup_write: assert property (setup_wr |=>
    CLOCK_EXTERNAL == $past(REG_WDATA[2])
    && SLEEP_ACTIVE == ($past(REG_WDATA[1]) && $past(REG_WDATA[2])))
    else $error("setup outputs wrong after write");
  chk_setup_read: assert property (REG_RD && REG_ADDR == `ADDR_SETUP |=>
    REG_RDATA[7:3] == 5'h00 && REG_RDATA[2:1] == $past({CLOCK_EXTERNAL, SLEEP_ACTIVE}))
    else $error("setup read wrong");
  chk_cap_write: assert property (REG_WR && REG_ADDR == `ADDR_CAP_BASE
    |=> CAP_SETTING[3:0] == $past(REG_WDATA[3:0]))
    else $error("red capacitor count not taken");
  chk_cap_unused: assert property (REG_RD && REG_ADDR inside {[8'h06:8'h09]}
    |=> REG_RDATA[7:4] == 4'h0)
    else $error("capacitor upper bits set");
  chk_slots_unused: assert property (REG_RD
    && REG_ADDR inside {8'h0B, 8'h0D, 8'h0F, 8'h11} |=> REG_RDATA[7:4] == 4'h0)
    else $error("slot high upper bits set");
  chk_result_unused: assert property (REG_RD && REG_ADDR[7:3] == 5'h08 && REG_ADDR[0]
    |=> REG_RDATA[7:2] == 6'h00)
    else $error("result high upper bits set");
  chk_unmapped_zero: assert property (REG_RD && REG_ADDR inside {[8'h12:8'h3F]}
    |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule // rgbc_light_sensor_regs_properties
`default_nettype wire

// ### verif/rgbc_light_sensor_regs_tb_top.sv
// Self-checking bench of the RGBC sensor register block
`timescale 1ns/100ps
`default_nettype none
`include "rgbc_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module rgbc_light_sensor_regs_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_clk = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, ext_on, sleep_on, busy;
  logic [15:0] caps;
  logic [9:0] v;
  realtime t0;
  rgbc_pkg::sample_set_t raw = {10'h100, 10'h200, 10'h3FE, 10'h005};
  rgbc_pkg::zero_set_t zero = {8'hFF, 8'h03, 8'h85, 8'h10};
  int bad_count = 0;
  int check_count = 0;
  // Core clock, and a slow external slot clock off the core edges
  initial forever #2.5 clk = ~clk;
  initial forever begin
    repeat (4) @(posedge clk);
    #1 ext_clk = ~ext_clk;
  end
  rgbc_light_sensor_regs rgbc_light_sensor_regs_inst (.CLK(clk), .RST_N(rst_n),
    .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .EXT_CLK(ext_clk), .SAMPLE_RAW(raw), .ZERO_RAW(zero), .CAP_SETTING(caps),
    .CLOCK_EXTERNAL(ext_on), .SLEEP_ACTIVE(sleep_on), .CONV_BUSY(busy));
  host_model host_model_inst (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded poll until both request bits have cleared themselves
  task automatic wait_idle();
    for (int i = 0; i < 1000; i++) begin
      host_model_inst.rd_reg(`ADDR_CTRL, d);
      if (d[1:0] === 2'b00) return;
    end
    bad_count++;
    test_done();
  endtask
  function automatic logic [9:0] want(logic [9:0] r, rgbc_pkg::zero_level_t z, logic t);
    int s;
    s = !t ? int'(r) : z.negative ? int'(r) + int'(z.magnitude) : int'(r) - int'(z.magnitude);
    return s < 0 ? 10'h000 : s > 1023 ? 10'h3FF : 10'(s);
  endfunction
  task automatic conv(input logic t);
    host_model_inst.wr_reg(`ADDR_CTRL, 8'h01);
    wait_idle();
    `CHK(busy, 1'b0)
    for (int i = 0; i < 4; i++) begin
      host_model_inst.rd_result(i, v);
      `CHK(v, want(raw[i], zero[i], t))
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK(caps, 16'hFFFF)
    for (int i = 0; i < 4; i++) begin
      host_model_inst.rd_reg(8'(`ADDR_CAP_BASE + i), d);
      `CHK(d, 8'h0F)
      host_model_inst.wr_reg(8'(`ADDR_CAP_BASE + i), 8'hF0 | 8'(i));
      host_model_inst.rd_reg(8'(`ADDR_CAP_BASE + i), d);
      `CHK(d, 8'(i))
      host_model_inst.wr_reg(8'(`ADDR_SLOTS_BASE + 2 * i), 8'(i));
      host_model_inst.wr_reg(8'(`ADDR_SLOTS_BASE + 2 * i + 1), 8'hFF);
      host_model_inst.rd_reg(8'(`ADDR_SLOTS_BASE + 2 * i + 1), d);
      `CHK(d, 8'h0F)
      host_model_inst.wr_reg(8'(`ADDR_SLOTS_BASE + 2 * i + 1), 8'hF0);
      host_model_inst.rd_reg(8'(`ADDR_SLOTS_BASE + 2 * i), d);
      `CHK(d, 8'(i))
    end
    `CHK(caps, 16'h3210)
    host_model_inst.rd_reg(8'h20, d);
    `CHK(d, 8'h00)
    host_model_inst.wr_reg(`ADDR_RESULT_BASE, 8'h5A);
    host_model_inst.rd_reg(`ADDR_RESULT_BASE, d);
    `CHK(d, 8'h00)
    host_model_inst.wr_reg(`ADDR_SETUP, 8'hFA);
    host_model_inst.rd_reg(`ADDR_SETUP, d);
    `CHK(d, 8'h00)
    // Offsets first, so the trimmed pass uses stored values
    host_model_inst.wr_reg(`ADDR_CTRL, 8'h02);
    wait_idle();
    for (int i = 0; i < 4; i++) begin
      host_model_inst.rd_reg(8'(`ADDR_ZERO_BASE + i), d);
      `CHK(d, zero[i])
    end
    conv(1'b0);
    host_model_inst.wr_reg(`ADDR_SETUP, 8'h01);
    conv(1'b1);
    host_model_inst.wr_reg(`ADDR_SETUP, 8'h04);
    `CHK(ext_on, 1'b1)
    t0 = $realtime;
    conv(1'b0);
    `CHK(($realtime - t0) < 1000.0, 1'b1)
    // Sleep holds a request back until it is lifted
    host_model_inst.wr_reg(`ADDR_SETUP, 8'h06);
    `CHK(sleep_on, 1'b1)
    host_model_inst.wr_reg(`ADDR_CTRL, 8'h01);
    repeat (50) @(posedge clk);
    #1;
    `CHK(busy, 1'b0)
    host_model_inst.wr_reg(`ADDR_SETUP, 8'h04);
    `CHK(sleep_on, 1'b0)
    wait_idle();
    test_done();
  end
endmodule // rgbc_light_sensor_regs_tb_top
bind rgbc_light_sensor_regs rgbc_light_sensor_regs_properties chk_inst (.CLK(CLK),
  .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .EXT_CLK(EXT_CLK), .SAMPLE_RAW(SAMPLE_RAW),
  .ZERO_RAW(ZERO_RAW), .CAP_SETTING(CAP_SETTING), .CLOCK_EXTERNAL(CLOCK_EXTERNAL),
  .SLEEP_ACTIVE(SLEEP_ACTIVE), .CONV_BUSY(CONV_BUSY));
`default_nettype wire
